/* File: src/imr_master_rx.sv */
// I2C master receiver byte-mode sequencer with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`include "imr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module imr_master_rx (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	output logic             intN
);

	localparam int QTR_CYCLES = (`IMR_SCL_QTR_NS * `IMR_REF_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);

	imr_pkg::imr_state_s r;
	imr_pkg::imr_state_s next_r;
	logic [1:0]          pinSync;
	logic                sclSync;
	logic                sdaSync;

	// =======================================================================
	// Pin synchronisers
	imr_sync #(
		.WIDTH   (2)
	) pinSyncer (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pinIn   ({sclIn, sdaIn}),
		.pinSync (pinSync)
	);

	assign sclSync = pinSync[1];
	assign sdaSync = pinSync[0];

	// =======================================================================
	// Register decode: bit 2 valid, bits 1:0 index
	function automatic logic [2:0] regSel(input logic [7:0] addr);
		regSel = {(addr[7:4] == 4'h0) && (addr[1:0] == 2'h0), addr[3:2]};
	endfunction

	// =======================================================================
	// Next state
	always_comb
	begin
		logic [2:0] sel;
		logic       qDone;
		logic       ackNow;
		sel     = 3'h0;
		qDone   = 1'b0;
		ackNow  = 1'b0;
		next_r  = r;

		// Write channel: address and data taken in either order
		if (awvalid && !r.awHave)
		begin
			next_r.awHave = 1'b1;
			next_r.awAddr = awaddr;
		end
		if (wvalid && !r.wHave)
		begin
			next_r.wHave = 1'b1;
			next_r.wByte = wdata[7:0];
			next_r.wLane = wstrb[0];
		end
		if (bready && r.bvalid)
		begin
			next_r.bvalid = 1'b0;
		end
		if (r.awHave && r.wHave && !r.bvalid)
		begin
			sel           = regSel(r.awAddr);
			next_r.awHave = 1'b0;
			next_r.wHave  = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = sel[2] ? `IMR_RESP_OKAY : `IMR_RESP_SLVERR;
			if (sel[2] && r.wLane)
			begin
				unique case ({4'h0, sel[1:0], 2'h0})
					`IMR_OFS_CONTROL:
					begin
						next_r.control              = r.wByte;
						next_r.control[`IMR_CTL_SI] = 1'b0;
					end
					`IMR_OFS_STATUS:
					begin
						next_r.status = r.status;
					end
					`IMR_OFS_DATA:
					begin
						next_r.dataReg = r.wByte;
					end
					`IMR_OFS_OWN_ADDR:
					begin
						next_r.ownAddr = r.wByte;
					end
				endcase
			end
		end

		// Read channel
		if (rready && r.rvalid)
		begin
			next_r.rvalid = 1'b0;
		end
		if (arvalid && !r.rvalid)
		begin
			sel           = regSel(araddr);
			next_r.rvalid = 1'b1;
			next_r.rresp  = sel[2] ? `IMR_RESP_OKAY : `IMR_RESP_SLVERR;
			next_r.rByte  = 8'h00;
			if (sel[2])
			begin
				unique case ({4'h0, sel[1:0], 2'h0})
					`IMR_OFS_CONTROL:  next_r.rByte = r.control & 8'hf9;
					`IMR_OFS_STATUS:   next_r.rByte = r.status;
					`IMR_OFS_DATA:     next_r.rByte = r.dataReg;
					`IMR_OFS_OWN_ADDR: next_r.rByte = r.ownAddr;
				endcase
			end
		end

		// Bus monitor: START sets busy, STOP clears it
		next_r.sclSeen = sclSync;
		next_r.sdaSeen = sdaSync;
		if (sclSync && r.sclSeen && r.sdaSeen && !sdaSync)
		begin
			next_r.busy = 1'b1;
		end
		if (sclSync && r.sclSeen && !r.sdaSeen && sdaSync)
		begin
			next_r.busy = 1'b0;
		end

		// Quarter-bit timer; stretched low clock and a foreign clock both hold it
		qDone = (r.tick == QTR_LAST)
			&& !(r.quarter == 2'h1 && !sclSync)
			&& !(r.quarter == 2'h3 && r.lost && sclSync);
		next_r.tick = qDone ? 8'h00 : ((r.tick == QTR_LAST) ? r.tick : r.tick + 8'h01);
		if (qDone)
		begin
			next_r.quarter = r.quarter + 2'h1;
		end

		unique case (r.state)
			imr_pkg::IMR_IDLE:
			begin
				next_r.tick    = 8'h00;
				next_r.quarter = 2'h0;
				next_r.sclLow  = 1'b0;
				next_r.sdaLow  = 1'b0;
				next_r.lost    = 1'b0;
				if (r.control[`IMR_CTL_BEGIN] && !r.busy)
				begin
					next_r.state    = imr_pkg::IMR_START;
					next_r.repeated = 1'b0;
				end
			end
			imr_pkg::IMR_START:
			begin
				if (qDone)
				begin
					unique case (r.quarter)
						2'h0: next_r.sclLow = 1'b0;
						2'h1: next_r.sdaLow = 1'b1;
						2'h2: next_r.sclLow = 1'b1;
						2'h3:
						begin
							next_r.state                   = imr_pkg::IMR_WAIT;
							next_r.control[`IMR_CTL_BEGIN] = 1'b0;
							next_r.control[`IMR_CTL_SI]    = 1'b1;
							next_r.status = r.repeated ? `IMR_ST_RESTART : `IMR_ST_START;
						end
					endcase
				end
			end
			imr_pkg::IMR_XFER:
			begin
				if (qDone)
				begin
					unique case (r.quarter)
						2'h0: next_r.sclLow = 1'b0;
						2'h1:
						begin
							if (r.bitCnt[3])
							begin
								next_r.ackSeen = !sdaSync;
							end
							else
							begin
								next_r.rxShift = {r.rxShift[6:0], sdaSync};
								if (r.addrPhase && !r.lost && !r.sdaLow && !sdaSync)
								begin
									next_r.lost   = 1'b1;
									next_r.sclLow = 1'b0;
								end
							end
						end
						2'h2: next_r.sclLow = !r.lost;
						2'h3:
						begin
							next_r.bitCnt  = r.bitCnt + 4'h1;
							next_r.txShift = {r.txShift[6:0], 1'b0};
							if (r.bitCnt < 4'h7)
							begin
								next_r.sdaLow = r.addrPhase && !r.lost && !r.txShift[6];
							end
							else if (r.bitCnt == 4'h7)
							begin
								ackNow = r.control[`IMR_CTL_ACK] && ((r.rxShift[7:1] == r.ownAddr[7:1])
									|| (r.rxShift == 8'h00 && r.ownAddr[`IMR_OWN_GC]));
								next_r.slaveAck = ackNow;
								next_r.sdaLow   = r.lost ? ackNow : (!r.addrPhase && r.ackEnable);
							end
							else
							begin
								next_r.sdaLow               = 1'b0;
								next_r.state                = imr_pkg::IMR_WAIT;
								next_r.control[`IMR_CTL_SI] = 1'b1;
								if (r.lost)
								begin
									next_r.sclLow = 1'b0;
									if (!r.slaveAck)
										next_r.status = `IMR_ST_ARB_LOST;
									else if (r.rxShift == 8'h00)
										next_r.status = `IMR_ST_SLV_GC;
									else if (r.rxShift[0])
										next_r.status = `IMR_ST_SLV_TX;
									else
										next_r.status = `IMR_ST_SLV_RX;
								end
								else if (r.addrPhase && r.readDir)
								begin
									next_r.status = r.ackSeen ? `IMR_ST_R_ACK : `IMR_ST_R_NACK;
								end
								else if (r.addrPhase)
								begin
									next_r.status = r.ackSeen ? `IMR_ST_W_ACK : `IMR_ST_W_NACK;
								end
								else
								begin
									next_r.dataReg = r.rxShift;
									next_r.status  = r.ackEnable ? `IMR_ST_DATA_ACK : `IMR_ST_DATA_NACK;
								end
							end
						end
					endcase
				end
			end
			imr_pkg::IMR_STOP:
			begin
				if (qDone)
				begin
					unique case (r.quarter)
						2'h0: next_r.sclLow = 1'b0;
						2'h1: next_r.sdaLow = 1'b0;
						2'h2: next_r.sdaLow = 1'b0;
						2'h3:
						begin
							next_r.state                 = imr_pkg::IMR_IDLE;
							next_r.control[`IMR_CTL_END] = 1'b0;
						end
					endcase
				end
			end
			imr_pkg::IMR_WAIT:
			begin
				next_r.tick    = 8'h00;
				next_r.quarter = 2'h0;
				next_r.bitCnt  = 4'h0;
				if (!r.control[`IMR_CTL_SI])
				begin
					unique case (r.status)
						`IMR_ST_START, `IMR_ST_RESTART:
						begin
							next_r.state     = imr_pkg::IMR_XFER;
							next_r.addrPhase = 1'b1;
							next_r.readDir   = r.dataReg[0];
							next_r.txShift   = r.dataReg;
							next_r.sdaLow    = !r.dataReg[7];
						end
						`IMR_ST_R_ACK, `IMR_ST_DATA_ACK:
						begin
							next_r.state     = imr_pkg::IMR_XFER;
							next_r.addrPhase = 1'b0;
							next_r.ackEnable = r.control[`IMR_CTL_ACK];
							next_r.sdaLow    = 1'b0;
						end
						`IMR_ST_R_NACK, `IMR_ST_DATA_NACK, `IMR_ST_W_ACK, `IMR_ST_W_NACK:
						begin
							if (r.control[`IMR_CTL_END])
							begin
								next_r.state  = imr_pkg::IMR_STOP;
								next_r.sdaLow = 1'b1;
							end
							else if (r.control[`IMR_CTL_BEGIN])
							begin
								next_r.state    = imr_pkg::IMR_START;
								next_r.repeated = 1'b1;
								next_r.sdaLow   = 1'b0;
							end
						end
						default:
						begin
							next_r.state = imr_pkg::IMR_IDLE;
						end
					endcase
				end
			end
			default:
			begin
				next_r.state = imr_pkg::IMR_IDLE;
			end
		endcase

		// Interface disabled: bus released, enable itself never touched here
		if (!r.control[`IMR_CTL_ENABLE])
		begin
			next_r.state  = imr_pkg::IMR_IDLE;
			next_r.sclLow = 1'b0;
			next_r.sdaLow = 1'b0;
		end
	end

	// =======================================================================
	// State register
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			r         <= '0;
			r.state   <= imr_pkg::IMR_IDLE;
			r.control <= `IMR_CONTROL_RESET;
			r.status  <= `IMR_STATUS_RESET;
			r.dataReg <= `IMR_DATA_RESET;
			r.ownAddr <= `IMR_OWN_ADDR_RESET;
			r.sclSeen <= 1'b1;
			r.sdaSeen <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	// =======================================================================
	// Outputs
	assign awready = !r.awHave;
	assign wready  = !r.wHave;
	assign bvalid  = r.bvalid;
	assign bresp   = r.bresp;
	assign arready = !r.rvalid;
	assign rvalid  = r.rvalid;
	assign rresp   = r.rresp;
	assign rdata   = {24'h000000, r.rByte};
	assign sclOut  = 1'b0;
	assign sdaOut  = 1'b0;
	assign sclOe   = r.sclLow;
	assign sdaOe   = r.sdaLow;
	assign intN    = !r.control[`IMR_CTL_SI];

endmodule // imr_master_rx

`default_nettype wire

/* File: src/imr_pkg.sv */
// Types shared by the master receiver design
package imr_pkg;

	// =======================================================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		IMR_IDLE  = 3'h0,
		IMR_START = 3'h1,
		IMR_XFER  = 3'h3,
		IMR_WAIT  = 3'h2,
		IMR_STOP  = 3'h6
	} imr_state_e;

	// =======================================================================
	// Complete state of the main module
	typedef struct packed
	{
		imr_state_e  state;
		logic [1:0]  quarter;
		logic [7:0]  tick;
		logic [3:0]  bitCnt;
		logic [7:0]  txShift;
		logic [7:0]  rxShift;
		logic        addrPhase;
		logic        readDir;
		logic        lost;
		logic        ackEnable;
		logic        slaveAck;
		logic        ackSeen;
		logic        repeated;
		logic        sclLow;
		logic        sdaLow;
		logic        busy;
		logic        sclSeen;
		logic        sdaSeen;
		logic [7:0]  control;
		logic [7:0]  status;
		logic [7:0]  dataReg;
		logic [7:0]  ownAddr;
		logic        awHave;
		logic [7:0]  awAddr;
		logic        wHave;
		logic [7:0]  wByte;
		logic        wLane;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [7:0]  rByte;
		logic [1:0]  rresp;
	} imr_state_s;

endpackage

/* File: src/imr_regs.svh */
// Register offsets, field positions, status codes and timing of the master receiver
`ifndef IMR_REGS_SVH
`define IMR_REGS_SVH

// ===========================================================================
// Register byte offsets
`define IMR_OFS_CONTROL     8'h00
`define IMR_OFS_STATUS      8'h04
`define IMR_OFS_DATA        8'h08
`define IMR_OFS_OWN_ADDR    8'h0c

// ===========================================================================
// Control register fields and the own-address general-call bit
`define IMR_CTL_ACK         7
`define IMR_CTL_ENABLE      6
`define IMR_CTL_BEGIN       5
`define IMR_CTL_END         4
`define IMR_CTL_SI          3
`define IMR_CTL_MODE        0
`define IMR_OWN_GC          0

// ===========================================================================
// Reset values
`define IMR_CONTROL_RESET   8'h00
`define IMR_STATUS_RESET    8'hf8
`define IMR_DATA_RESET      8'h00
`define IMR_OWN_ADDR_RESET  8'h00

// ===========================================================================
// Status codes
`define IMR_ST_START        8'h08
`define IMR_ST_RESTART      8'h10
`define IMR_ST_W_ACK        8'h18
`define IMR_ST_W_NACK       8'h20
`define IMR_ST_ARB_LOST     8'h38
`define IMR_ST_R_ACK        8'h40
`define IMR_ST_R_NACK       8'h48
`define IMR_ST_DATA_ACK     8'h50
`define IMR_ST_DATA_NACK    8'h58
`define IMR_ST_SLV_RX       8'h68
`define IMR_ST_SLV_TX       8'hb0
`define IMR_ST_SLV_GC       8'hd8

// ===========================================================================
// Bus answers and timing
`define IMR_RESP_OKAY       2'h0
`define IMR_RESP_SLVERR     2'h2
`define IMR_REF_CLK_MHZ     20
`define IMR_SCL_QTR_NS      2500

`endif

/* File: src/imr_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module imr_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} imr_sync_s;

	imr_sync_s r;
	imr_sync_s next_r;

	always_comb
	begin
		next_r.meta   = pinIn;
		next_r.stable = r.meta;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			r <= '1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign pinSync = r.stable;

endmodule // imr_sync

`default_nettype wire

/* File: tb/imr_bus_partner.sv */
// Slave transmitter and rival master on the serial link
`timescale 1ns/1ps
`default_nettype none

module imr_bus_partner #(
	parameter logic [6:0] SLV = 7'h50
) (
	input  wire logic       sclW,
	input  wire logic       sdaW,
	input  wire logic       rivalOn,
	input  wire logic [7:0] rivalByte,
	input  wire logic [7:0] txData,
	output logic            sclLow,
	output logic            masterNack,
	output logic            sdaLow
);
	logic       sLow;
	logic       rSda;
	logic [7:0] adr;
	logic [7:0] b;

	assign sdaLow = sLow | rSda;

	initial
	begin
		sLow = 1'b0;
		rSda = 1'b0;
		sclLow = 1'b0;
		masterNack = 1'b1;
	end

	// ==========================================
	// Slave transmitter, armed by each start
	always @(negedge sdaW)
	begin : slave
		int n;
		if (sclW)
		begin
			for (n = 0; n < 8; n++)
				@(posedge sclW) adr = {adr[6:0], sdaW};
			@(negedge sclW) #300 sLow = (adr[7:1] == SLV);
			@(negedge sclW) #300 sLow = 1'b0;
			if (adr[7:1] == SLV && adr[0])
			begin
				do
				begin
					b = txData;
					for (n = 7; n >= 0; n--)
					begin
						sLow = !b[n];
						@(negedge sclW) #300;
					end
					sLow = 1'b0;
					@(posedge sclW) masterNack = sdaW;
					@(negedge sclW) #300;
				end while (!masterNack);
			end
		end
	end

	// ==========================================
	// Rival master: own clock, own address, then stop
	always @(negedge sdaW)
	begin : rival
		int k;
		if (sclW && rivalOn)
		begin
			@(negedge sclW);
			for (k = 0; k < 9; k++)
			begin
				sclLow = 1'b1;
				#300 rSda = (k < 8) && !rivalByte[7 - k];
				#4700 sclLow = 1'b0;
				@(posedge sclW) #5000;
			end
			sclLow = 1'b1;
			#300 rSda = 1'b1;
			#5000 sclLow = 1'b0;
			#5000 rSda = 1'b0;
		end
	end
endmodule // imr_bus_partner

`default_nettype wire

/* File: tb/imr_checker.sv */
// Port-level assertions for the master receiver
`timescale 1ns/1ps
`default_nettype none
`include "imr_regs.svh"

module imr_checker (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [3:0]  wstrb,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        sclIn,
	input wire logic        sclOe,
	input wire logic        sdaOe,
	input wire logic        intN
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	// ==========================================
	// Steps
	sequence wrTake;
		awvalid && awready && wvalid && wready && !bvalid;
	endsequence
	sequence ctlWrite;
		wrTake ##0 (awaddr == `IMR_OFS_CONTROL && wstrb[0]);
	endsequence
	sequence startSeen;
		$rose(sdaOe) && !sclOe && sclIn;
	endsequence
	sequence stopSeen;
		$fell(sdaOe) && !sclOe && sclIn;
	endsequence

	// ==========================================
	// Properties
	a_wr_answer: assert property (wrTake |-> ##2 bvalid)
		else $error("write not answered");
	a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_rd_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_start_flag: assert property (startSeen |-> ##[1:400] !intN)
		else $error("no flag after start");
	a_ctl_clear: assert property (ctlWrite |-> ##[1:3] intN)
		else $error("control write kept flag");
	a_wait_holds: assert property (!intN && sclOe |=> sclOe || intN)
		else $error("clock released while flagged");
	a_stop_free: assert property (stopSeen |=> !sclOe [*8])
		else $error("clock pulled after stop");
endmodule // imr_checker

bind imr_master_rx imr_checker u_imr_checker (.ref_clk, .reset, .awaddr, .awvalid, .awready, .wstrb, .wvalid,
	.wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .sclIn, .sclOe, .sdaOe,
	.intN);

`default_nettype wire

/* File: tb/imr_master_rx_tb_top.sv */
// Self-checking bench for the master receiver
`timescale 1ns/1ps
`default_nettype none
`include "imr_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t %h %h", $time, g, e); end end

module imr_master_rx_tb_top;
	localparam logic [7:0] AK = 8'h01 << `IMR_CTL_ACK;
	localparam logic [7:0] EN = 8'h01 << `IMR_CTL_ENABLE;
	localparam logic [7:0] BG = 8'h01 << `IMR_CTL_BEGIN;
	localparam logic [7:0] ED = 8'h01 << `IMR_CTL_END;
	localparam logic [7:0] SI = 8'h01 << `IMR_CTL_SI;
	localparam logic [1:0] OK = `IMR_RESP_OKAY;
	localparam logic [1:0] ER = `IMR_RESP_SLVERR;
	localparam logic [6:0] OWNA = 7'h3a;
	localparam logic [6:0] SLV = 7'h50;
	localparam logic [7:0] RIV [4] = '{{OWNA, 1'b1}, {OWNA, 1'b0}, 8'h00, 8'h20};
	localparam logic [7:0] LOST [4] = '{`IMR_ST_SLV_TX, `IMR_ST_SLV_RX, `IMR_ST_SLV_GC, `IMR_ST_ARB_LOST};

	logic        ref_clk;
	logic        reset;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        sclOe;
	logic        sdaOe;
	logic        sclLow;
	logic        sdaLow;
	logic        sclW;
	logic        sdaW;
	logic        intN;
	logic        nack;
	logic        rivalOn;
	logic [7:0]  rivalByte;
	logic [7:0]  txData;
	logic [7:0]  q [$];
	int          seed;
	int          n_mismatch;
	int          total_checks;

	// Open-drain wires with pull-ups
	assign sclW = !sclOe && !sclLow;
	assign sdaW = !sdaOe && !sdaLow;

	imr_master_rx u_imr_master_rx (.ref_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.sclIn(sclW), .sclOut(), .sclOe, .sdaIn(sdaW), .sdaOut(), .sdaOe, .intN);

	imr_bus_partner #(.SLV(SLV)) u_imr_bus_partner (.sclW, .sdaW, .rivalOn, .rivalByte, .txData, .sclLow,
		.masterNack(nack), .sdaLow);

	initial
		ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	// ==========================================
	// Bus tasks
	task automatic print_verdict;
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic quit;
		n_mismatch++;
		print_verdict;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic awT;
		logic wT;
		logic bT;
		logic [1:0] got;
		awT = 1'b0;
		wT = 1'b0;
		bT = 1'b0;
		got = 2'h0;
		awaddr <= a;
		wdata <= ($random(seed) & 32'hffffff00) | {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 99; n++)
		begin
			// Handshakes judged on settled values before the edge
			@(negedge ref_clk);
			awT = awvalid && awready;
			wT = wvalid && wready;
			bT = bvalid && bready;
			got = bresp;
			@(posedge ref_clk);
			if (awT)
				awvalid <= 1'b0;
			if (wT)
				wvalid <= 1'b0;
			if (bT)
				break;
			if (n < 98 && !bready)
				bready <= 1'($random(seed));
		end
		bready <= 1'b0;
		`CHK(got, er)
		if (n == 99)
			quit;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		logic arT;
		logic rT;
		logic [31:0] got;
		logic [1:0] gotResp;
		arT = 1'b0;
		rT = 1'b0;
		got = 32'h0;
		gotResp = 2'h0;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 99; n++)
		begin
			@(negedge ref_clk);
			arT = arvalid && arready;
			rT = rvalid && rready;
			got = rdata;
			gotResp = rresp;
			@(posedge ref_clk);
			if (arT)
				arvalid <= 1'b0;
			if (rT)
				break;
			if (n < 98 && !rready)
				rready <= 1'($random(seed));
		end
		rready <= 1'b0;
		`CHK(got, {24'h0, e})
		`CHK(gotResp, er)
		if (n == 99)
			quit;
	endtask

	task automatic step(input logic [7:0] c, input logic [7:0] st);
		int n;
		wr(`IMR_OFS_CONTROL, c, OK);
		repeat (2) @(posedge ref_clk);
		for (n = 0; n < 5000 && intN !== 1'b0; n++)
			@(posedge ref_clk);
		if (n == 5000)
			quit;
		rd(`IMR_OFS_STATUS, st, OK);
	endtask

	task automatic nxt;
		logic [7:0] x;
		x = 8'($random(seed));
		txData <= x;
		q.push_back(x);
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		int i;
		seed = 32'he2170a13;
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		{rivalOn, rivalByte, txData} = '0;
		n_mismatch = 0;
		total_checks = 0;
		reset = 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`IMR_OFS_CONTROL, `IMR_CONTROL_RESET, OK);
		rd(`IMR_OFS_STATUS, `IMR_STATUS_RESET, OK);
		rd(`IMR_OFS_DATA, `IMR_DATA_RESET, OK);
		rd(`IMR_OFS_OWN_ADDR, `IMR_OWN_ADDR_RESET, OK);
		rd(8'h10, 8'h00, ER);
		wr(8'h13, 8'h5a, ER);
		wr(`IMR_OFS_OWN_ADDR, {OWNA, 1'b1}, OK);
		for (i = 0; i < 4; i++)
		begin
			rivalByte <= RIV[i];
			rivalOn <= 1'b1;
			step(EN | BG | AK, `IMR_ST_START);
			wr(`IMR_OFS_DATA, 8'hff, OK);
			step(EN | AK, LOST[i]);
			rivalOn <= 1'b0;
			if (i < 3)
				wr(`IMR_OFS_CONTROL, EN | AK, OK);
			else
				step(EN | BG, `IMR_ST_START);
		end
		nxt;
		// Target differs from own address
		wr(`IMR_OFS_DATA, {SLV, 1'b1}, OK);
		step(EN | AK, `IMR_ST_R_ACK);
		for (i = 0; i < 2; i++)
		begin
			nxt;
			step(i == 0 ? EN | AK : EN, i == 0 ? `IMR_ST_DATA_ACK : `IMR_ST_DATA_NACK);
			`CHK(nack, 1'(i))
			rd(`IMR_OFS_DATA, q.pop_front(), OK);
		end
		step(EN | BG, `IMR_ST_RESTART);
		wr(`IMR_OFS_DATA, {SLV + 7'h1, 1'b1}, OK);
		step(EN, `IMR_ST_R_NACK);
		step(EN | BG | ED, `IMR_ST_START);
		rd(`IMR_OFS_CONTROL, EN | SI, OK);
		wr(`IMR_OFS_DATA, {SLV, 1'b0}, OK);
		step(EN, `IMR_ST_W_ACK);
		wr(`IMR_OFS_CONTROL, EN | ED, OK);
		for (i = 0; i < 999 && (sclOe !== 1'b0 || sdaOe !== 1'b0); i++)
			@(posedge ref_clk);
		if (i == 999)
			quit;
		// End request clears only when the stop sequence has finished
		repeat (200) @(posedge ref_clk);
		rd(`IMR_OFS_CONTROL, EN, OK);
		`CHK(intN, 1'b1)
		print_verdict;
	end
endmodule // imr_master_rx_tb_top

`default_nettype wire
